// ---- rtl/lan_ctrl_map.svh ----
// Register indices, field positions, reset values and timing counts
// Assumes inclusion by bare name from the reset sequencer, the core and the bench
`ifndef LAN_CTRL_MAP_SVH
`define LAN_CTRL_MAP_SVH

`define BUS_MODE_IDX        4'h0
`define INT_STATUS_IDX      4'h5
`define INT_MASK_IDX        4'h7

`define BM_SOFT_RESET_BIT   0
`define BM_RX_PRIO_BIT      1
`define BUS_MODE_RESET      32'h0000_0000
`define INT_MASK_RESET      32'h0000_0000
`define INT_STATUS_RESET    32'h0000_0000

// Implemented interrupt source positions: 0-3, 5-11, 13, 14
`define INT_SRC_BITS        32'h0000_6fef
`define IS_TX_DONE          0
`define IS_TX_STOPPED       1
`define IS_TX_BUF_UNAVAIL   2
`define IS_JABBER_TIMEOUT   3
`define IS_TX_UNDERFLOW     5
`define IS_RX_DONE          6
`define IS_RX_BUF_UNAVAIL   7
`define IS_RX_STOPPED       8
`define IS_RX_WATCHDOG      9
`define IS_EARLY_TX         10
`define IS_GP_TIMER         11
`define IS_FATAL_BUS_ERR    13
`define IS_EARLY_RX         14

`define HOST_WAIT_CYCLES    50
`define RESET_SEQ_CYCLES    16

`endif

// ---- rtl/lan_ctrl_pkg.sv ----
// Types shared by the DMA arbiter, reset sequencer and request collector
// Enum encodings are given here; lan_ctrl_map.svh supplies the other numeric constants
package lan_ctrl_pkg;

	typedef logic [31:0] word_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] idx;
		word_t      wdata;
	} csr_req_t;

	typedef struct packed {
		logic desc_fetch;
		logic desc_close;
		logic setup_pkt;
		logic fifo_room;
	} tx_src_t;

	typedef struct packed {
		logic desc_fetch;
		logic desc_close;
		logic fifo_burst;
		logic pkt_end;
	} rx_src_t;

	typedef struct packed {
		logic transmitting_now;
		logic rx_fifo_space_low;
		logic tx_fifo_level_low;
		logic full_duplex;
	} link_state_t;

	typedef enum logic [1:0] {
		GRANT_IDLE = 2'b00,
		GRANT_RX   = 2'b01,
		GRANT_TX   = 2'b10
	} grant_state_t;

	typedef enum logic [1:0] {
		RST_IDLE = 2'b00,
		RST_RUN  = 2'b01
	} reset_state_t;

endpackage

// ---- rtl/reset_sequencer.sv ----
// Reset sequence timer for hardware and software reset
// Assumes soft_reset_req is a one-cycle pulse on ref_clk
`include "lan_ctrl_map.svh"

module reset_sequencer
	import lan_ctrl_pkg::*;
#(
	parameter int SEQ_CYCLES = `RESET_SEQ_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic soft_reset_req,
	output logic      seq_busy_ff,
	output logic      cfg_init_ff
);

	// Host may touch the device after its wait, so the sequence must end first
	if (SEQ_CYCLES < 1 || SEQ_CYCLES >= `HOST_WAIT_CYCLES) begin : g_bad_len
		$error("reset sequence must be shorter than the host wait");
	end

	reset_state_t state_ff, nxt_state;
	logic [7:0]   count_ff, nxt_count;
	logic         nxt_busy, nxt_cfg;

	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		nxt_busy  = seq_busy_ff;
		nxt_cfg   = cfg_init_ff;
		unique case (state_ff)
			RST_IDLE: begin
				if (soft_reset_req) begin
					nxt_state = RST_RUN;
					nxt_count = 8'h00;
					nxt_busy  = 1'b1;
				end
			end
			RST_RUN: begin
				nxt_count = count_ff + 8'h01;
				if (count_ff == 8'(SEQ_CYCLES - 1)) begin
					nxt_state = RST_IDLE;
					nxt_busy  = 1'b0;
					nxt_cfg   = 1'b0;
				end
			end
			default: begin
				nxt_state = RST_RUN;
				nxt_count = 8'h00;
				nxt_busy  = 1'b1;
			end
		endcase
	end

	// Pin reset starts a run with config init; a soft run leaves config alone
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff    <= RST_RUN;
			count_ff    <= 8'h00;
			seq_busy_ff <= 1'b1;
			cfg_init_ff <= 1'b1;
		end else begin
			state_ff    <= nxt_state;
			count_ff    <= nxt_count;
			seq_busy_ff <= nxt_busy;
			cfg_init_ff <= nxt_cfg;
		end
	end

endmodule

// ---- rtl/request_collector.sv ----
// Folds the per-cause DMA request lines of each process into one request
// Assumes all sources are logic on ref_clk
module request_collector
	import lan_ctrl_pkg::*;
(
	input  tx_src_t    tx_src,
	input  rx_src_t    rx_src,
	output logic [1:0] req
);

	logic [3:0] src [2];

	assign src[0] = rx_src;
	assign src[1] = tx_src;

	for (genvar i = 0; i < 2; i++) begin : g_proc
		assign req[i] = |src[i];
	end

endmodule

// ---- rtl/lan_dma_arbiter_reset_irq.sv ----
// Control core: reset sequencing, host-bus DMA arbitration, interrupt status
// Assumes the PCI target decodes CSR accesses into csr_req, and engines run on ref_clk
`include "lan_ctrl_map.svh"

module lan_dma_arbiter_reset_irq
	import lan_ctrl_pkg::*;
#(
	parameter int RESET_SEQ = `RESET_SEQ_CYCLES
) (
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  csr_req_t          csr_req,
	output word_t             csr_rdata_ff,
	output logic              csr_ack_ff,
	input  tx_src_t           tx_src,
	input  rx_src_t           rx_src,
	input  link_state_t       link,
	input  wire logic         dma_done,
	input  wire logic         rx_packet_end,
	input  wire logic         tx_packet_end,
	input  word_t             irq_events,
	output grant_state_t      grant_ff,
	output logic              engines_reset_ff,
	output logic              cfg_init_ff,
	output logic              irq_ff
);

	// The host wait keeps accesses clear of the sequence; any access during it is also dropped
	if (RESET_SEQ < 1 || RESET_SEQ >= `HOST_WAIT_CYCLES) begin : g_bad_seq
		$error("reset sequence must end inside the host wait");
	end

	// Pin reset asserts at once but releases through two flops, so every
	// register leaves reset on the same clean edge
	logic  rst_meta_n_ff;
	logic  rst_sync_n_ff;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_n_ff <= 1'b0;
			rst_sync_n_ff <= 1'b0;
		end else begin
			rst_meta_n_ff <= 1'b1;
			rst_sync_n_ff <= rst_meta_n_ff;
		end
	end

	// Reset sequencing

	logic  soft_reset_req;
	logic  seq_busy;
	logic  cfg_init;
	logic  wr_ok;
	logic  rd_ok;

	// Accesses during the sequence are dropped and get no acknowledge
	assign wr_ok = csr_req.wr & ~seq_busy;
	assign rd_ok = csr_req.rd & ~seq_busy;

	assign soft_reset_req = wr_ok && csr_req.idx == `BUS_MODE_IDX
		&& csr_req.wdata[`BM_SOFT_RESET_BIT];

	reset_sequencer #(
		.SEQ_CYCLES     (RESET_SEQ)
	) u_reset_seq (
		.ref_clk        (ref_clk),
		.reset_n        (rst_sync_n_ff),
		.soft_reset_req (soft_reset_req),
		.seq_busy_ff    (seq_busy),
		.cfg_init_ff    (cfg_init)
	);

	// Engines abort and park in stopped while the sequence runs
	always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			engines_reset_ff <= 1'b1;
			cfg_init_ff      <= 1'b1;
		end else begin
			engines_reset_ff <= seq_busy | soft_reset_req;
			cfg_init_ff      <= cfg_init;
		end
	end

	// Registers

	word_t bus_mode_ff,   nxt_bus_mode;
	word_t int_mask_ff,   nxt_int_mask;
	word_t int_status_ff, nxt_int_status;
	word_t nxt_rdata;
	logic  nxt_ack;
	logic  nxt_irq;
	logic  clear_hit;
	word_t clear_bits;

	// Only implemented sources can be cleared; the rest always read zero
	assign clear_bits = (wr_ok && csr_req.idx == `INT_STATUS_IDX) ?
		csr_req.wdata & `INT_SRC_BITS : 32'h0000_0000;
	assign clear_hit  = |(clear_bits & int_status_ff);

	always_comb begin
		nxt_bus_mode   = bus_mode_ff;
		nxt_int_mask   = int_mask_ff;
		nxt_int_status = int_status_ff;
		if (wr_ok && csr_req.idx == `BUS_MODE_IDX) begin
			// Soft reset bit self-clears, so it always reads back zero
			nxt_bus_mode = '0;
			nxt_bus_mode[`BM_RX_PRIO_BIT] = csr_req.wdata[`BM_RX_PRIO_BIT];
		end
		if (wr_ok && csr_req.idx == `INT_MASK_IDX) begin
			nxt_int_mask = csr_req.wdata & `INT_SRC_BITS;
		end
		// Set wins over clear so an event in the clearing cycle survives
		nxt_int_status = (int_status_ff & ~clear_bits)
			| (irq_events & `INT_SRC_BITS);
		if (seq_busy || soft_reset_req) begin
			nxt_bus_mode   = `BUS_MODE_RESET;
			nxt_int_mask   = `INT_MASK_RESET;
			nxt_int_status = `INT_STATUS_RESET;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			bus_mode_ff   <= `BUS_MODE_RESET;
			int_mask_ff   <= `INT_MASK_RESET;
			int_status_ff <= `INT_STATUS_RESET;
		end else begin
			bus_mode_ff   <= nxt_bus_mode;
			int_mask_ff   <= nxt_int_mask;
			int_status_ff <= nxt_int_status;
		end
	end

	// Read port: one-cycle answer, unmapped indices read zero
	// Unmapped writes are acknowledged too, so the host never stalls on a hole
	always_comb begin
		nxt_ack   = wr_ok | rd_ok;
		nxt_rdata = '0;
		if (rd_ok) begin
			unique case (csr_req.idx)
				`BUS_MODE_IDX:   nxt_rdata = bus_mode_ff;
				`INT_STATUS_IDX: nxt_rdata = int_status_ff;
				`INT_MASK_IDX:   nxt_rdata = int_mask_ff;
				default:         nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			csr_rdata_ff <= '0;
			csr_ack_ff   <= 1'b0;
		end else begin
			csr_rdata_ff <= nxt_rdata;
			csr_ack_ff   <= nxt_ack;
		end
	end

	// Interrupt line

	// A level of set-and-enabled bits; several events merge into one assertion.
	// A clearing write that hits a set bit forces one low cycle so an edge-
	// sensitive host sees the remaining causes as a fresh interrupt.
	always_comb begin
		nxt_irq = |(nxt_int_status & nxt_int_mask);
		if (clear_hit) begin
			nxt_irq = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	// DMA arbitration

	logic [1:0] req;
	logic       rx_req;
	logic       tx_req;

	request_collector u_req (
		.tx_src (tx_src),
		.rx_src (rx_src),
		.req    (req)
	);

	// Bit order follows the collector's source array: receive low, transmit high
	assign rx_req = req[0];
	assign tx_req = req[1];

	// rr_rx_ff remembers which process won last, for both round-robin cases
	grant_state_t nxt_grant;
	logic         owe_tx_ff,  nxt_owe_tx;
	logic         owe_rx_ff,  nxt_owe_rx;
	logic         rr_rx_ff,   nxt_rr_rx;
	logic         pick_rx;

	// Choice when both processes request; windows for the other side come first
	always_comb begin
		if (owe_tx_ff && !owe_rx_ff) begin
			pick_rx = 1'b0;
		end else if (owe_rx_ff && !owe_tx_ff) begin
			pick_rx = 1'b1;
		end else if (!bus_mode_ff[`BM_RX_PRIO_BIT]) begin
			pick_rx = ~rr_rx_ff;
		end else if (!link.transmitting_now) begin
			pick_rx = 1'b1;
		end else if (link.rx_fifo_space_low && !link.tx_fifo_level_low) begin
			pick_rx = 1'b1;
		end else if (link.rx_fifo_space_low && link.full_duplex) begin
			pick_rx = ~rr_rx_ff;
		end else begin
			pick_rx = 1'b0;
		end
	end

	always_comb begin
		nxt_grant  = grant_ff;
		nxt_owe_tx = owe_tx_ff | rx_packet_end;
		nxt_owe_rx = owe_rx_ff | tx_packet_end;
		nxt_rr_rx  = rr_rx_ff;
		unique case (grant_ff)
			GRANT_IDLE: begin
				// A grant lasts for one burst, ended by dma_done
				if (rx_req && (!tx_req || pick_rx)) begin
					nxt_grant  = GRANT_RX;
					nxt_rr_rx  = 1'b1;
					nxt_owe_rx = tx_packet_end;
					if (tx_req) begin
						nxt_owe_tx = rx_packet_end;
					end
				end else if (tx_req) begin
					nxt_grant  = GRANT_TX;
					nxt_rr_rx  = 1'b0;
					nxt_owe_tx = rx_packet_end;
					if (rx_req) begin
						nxt_owe_rx = tx_packet_end;
					end
				end
			end
			GRANT_RX, GRANT_TX: begin
				if (dma_done) begin
					nxt_grant = GRANT_IDLE;
				end
			end
			default: begin
				nxt_grant = GRANT_IDLE;
			end
		endcase
		// Reset drops any burst mid-flight; no descriptor is closed or released
		if (seq_busy || soft_reset_req) begin
			nxt_grant  = GRANT_IDLE;
			nxt_owe_tx = 1'b0;
			nxt_owe_rx = 1'b0;
			nxt_rr_rx  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			grant_ff  <= GRANT_IDLE;
			owe_tx_ff <= 1'b0;
			owe_rx_ff <= 1'b0;
			rr_rx_ff  <= 1'b0;
		end else begin
			grant_ff  <= nxt_grant;
			owe_tx_ff <= nxt_owe_tx;
			owe_rx_ff <= nxt_owe_rx;
			rr_rx_ff  <= nxt_rr_rx;
		end
	end

endmodule

// ---- bench/lan_dma_arbiter_reset_irq_asserts.sv ----
// Port-level checks for the control core
// Assumes one ref_clk domain and binding into the core by matching names
module core_asserts
	import lan_ctrl_pkg::*;
(
	input wire logic    ref_clk,
	input wire logic    reset_n,
	input csr_req_t     csr_req,
	input wire logic    csr_ack_ff,
	input tx_src_t      tx_src,
	input rx_src_t      rx_src,
	input word_t        irq_events,
	input grant_state_t grant_ff,
	input wire logic    engines_reset_ff,
	input wire logic    cfg_init_ff,
	input wire logic    irq_ff
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	logic idle;
	logic srst;
	logic quiet;
	assign idle  = grant_ff == GRANT_IDLE;
	assign srst  = csr_req.wr && csr_req.idx == 4'h0 && csr_req.wdata[0];
	// The sequence end may lag by a cycle, so demand two calm cycles
	assign quiet = !engines_reset_ff && !srst;

	a_no_req_idle: assert property (idle && tx_src == '0 && rx_src == '0 |=> idle)
		else $error("grant raised with no request");
	a_lone_rx: assert property (idle && tx_src == '0 && rx_src != '0 && quiet
		&& !$past(engines_reset_ff) |=> grant_ff == GRANT_RX)
		else $error("lone receive request not granted");
	a_lone_tx: assert property (idle && rx_src == '0 && tx_src != '0 && quiet
		&& !$past(engines_reset_ff) |=> grant_ff == GRANT_TX)
		else $error("lone transmit request not granted");
	a_soft_reset: assert property (srst && !engines_reset_ff
		|=> engines_reset_ff && idle && !irq_ff && !cfg_init_ff)
		else $error("soft reset did not abort cleanly");
	a_cfg_pin_only: assert property (!cfg_init_ff |=> !cfg_init_ff)
		else $error("config init raised without pin reset");
	a_ack_taken: assert property ((csr_req.wr || csr_req.rd) && quiet
		&& !$past(engines_reset_ff) |=> csr_ack_ff)
		else $error("access not acknowledged");
	a_seq_mute: assert property (engines_reset_ff |=> !csr_ack_ff)
		else $error("access acknowledged during reset sequence");
	a_irq_rise: assert property ($rose(irq_ff) |-> $past(irq_events) != '0
		|| $past(csr_req.wr) || $past(csr_req.wr, 2))
		else $error("interrupt rose without event or write");
	a_irq_hold: assert property (irq_ff && !csr_req.wr |=> irq_ff)
		else $error("interrupt dropped without a write");
endmodule

bind lan_dma_arbiter_reset_irq core_asserts core_asserts_inst (.*);

// ---- bench/host_model.sv ----
// Host and driver side of the register port
// Assumes the core acknowledges a taken access one edge later
`include "lan_ctrl_map.svh"

module host_model
	import lan_ctrl_pkg::*;
(
	input wire logic ref_clk,
	output csr_req_t csr_req,
	input word_t     csr_rdata_ff,
	input wire logic csr_ack_ff
);
	timeunit 1ns;
	timeprecision 1ns;

	initial csr_req = '0;

	// Request stands one cycle: holding it would count as a second access
	task automatic access(input logic w, input logic [3:0] idx, input word_t wd,
			output word_t rd, output logic ok);
		rd = '0;
		ok = 1'b0;
		@(posedge ref_clk);
		csr_req <= '{wr: w, rd: !w, idx: idx, wdata: wd};
		@(posedge ref_clk);
		csr_req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: ~wd};
		repeat (3) if (!ok) begin
			@(posedge ref_clk);
			ok = csr_ack_ff === 1'b1;
			rd = csr_rdata_ff;
		end
	endtask

	task automatic settle();
		repeat (`HOST_WAIT_CYCLES) @(posedge ref_clk);
	endtask
endmodule

// ---- bench/lan_dma_arbiter_reset_irq_tb.sv ----
// Self-checking bench: reset, interrupt status and DMA arbitration
// Assumes host_model owns the register port; the bench drives the engine side
`include "lan_ctrl_map.svh"

module lan_dma_arbiter_reset_irq_tb import lan_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic         ref_clk, reset_n, dma_done, rx_packet_end, tx_packet_end;
	logic         csr_ack_ff, engines_reset_ff, cfg_init_ff, irq_ff, irq_prev, ok;
	csr_req_t     csr_req;
	word_t        csr_rdata_ff, irq_events, rdv;
	tx_src_t      tx_src;
	rx_src_t      rx_src;
	link_state_t  link;
	grant_state_t grant_ff;
	int           miscompares = 0;
	int           checks = 0;

	lan_dma_arbiter_reset_irq #(.RESET_SEQ(4)) lan_dma_arbiter_reset_irq_inst (
		.ref_clk(ref_clk), .reset_n(reset_n), .csr_req(csr_req),
		.csr_rdata_ff(csr_rdata_ff), .csr_ack_ff(csr_ack_ff), .tx_src(tx_src),
		.rx_src(rx_src), .link(link), .dma_done(dma_done),
		.rx_packet_end(rx_packet_end), .tx_packet_end(tx_packet_end),
		.irq_events(irq_events), .grant_ff(grant_ff),
		.engines_reset_ff(engines_reset_ff), .cfg_init_ff(cfg_init_ff), .irq_ff(irq_ff));

	host_model host_model_inst (.ref_clk(ref_clk), .csr_req(csr_req),
		.csr_rdata_ff(csr_rdata_ff), .csr_ack_ff(csr_ack_ff));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Keeps the one-cycle drop visible after the write task returns
	always_ff @(posedge ref_clk) irq_prev <= irq_ff;

	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] idx, input word_t d);
		host_model_inst.access(1'b1, idx, d, rdv, ok);
	endtask

	task automatic rd_chk(input string what, input logic [3:0] idx, input word_t e);
		host_model_inst.access(1'b0, idx, '0, rdv, ok);
		check(what, e, rdv);
	endtask

	task automatic ev(input word_t b);
		@(posedge ref_clk);
		irq_events <= b;
		@(posedge ref_clk);
		irq_events <= '0;
		@(negedge ref_clk);
	endtask

	task automatic arb(input logic m, input logic [1:0] pe, input logic [3:0] t,
			input logic [3:0] r, input logic [3:0] l, input grant_state_t e);
		int n;
		wr(4'h0, {30'h0, m, 1'b0});
		@(posedge ref_clk);
		{tx_packet_end, rx_packet_end} <= pe;
		@(posedge ref_clk);
		{tx_packet_end, rx_packet_end} <= 2'b00;
		tx_src <= t;
		rx_src <= r;
		link <= l;
		for (n = 0; n < 8 && grant_ff === GRANT_IDLE; n++) @(negedge ref_clk);
		check("grant", {30'h0, e}, {30'h0, grant_ff});
		@(posedge ref_clk);
		dma_done <= 1'b1;
		@(posedge ref_clk);
		dma_done <= 1'b0;
		tx_src <= '0;
		rx_src <= '0;
		repeat (3) @(posedge ref_clk);
	endtask

	initial begin
		#100us;
		miscompares++;
		conclude();
	end

	initial begin
		reset_n = 1'b0;
		{dma_done, rx_packet_end, tx_packet_end} = 3'b000;
		irq_events = '0;
		tx_src = '0;
		rx_src = '0;
		link = '0;
		repeat (8) @(posedge ref_clk);
		check("cfg init in reset", 1, cfg_init_ff);
		check("engines in reset", 1, engines_reset_ff);
		reset_n <= 1'b1;
		host_model_inst.settle();
		check("engines stopped", 0, engines_reset_ff);
		check("cfg init done", 0, cfg_init_ff);
		rd_chk("status", 4'h5, 32'h0);
		rd_chk("unmapped", 4'h3, 32'h0);
		wr(4'h7, 32'hffff_ffff);
		rd_chk("mask", 4'h7, `INT_SRC_BITS);
		ev(32'h0000_0041);
		check("irq two events", 1, irq_ff);
		ev(32'h0000_0081);
		rd_chk("status", 4'h5, 32'h0000_00c1);
		wr(4'h5, 32'h0000_0041);
		@(negedge ref_clk);
		check("irq drop", 0, irq_prev);
		check("irq back", 1, irq_ff);
		wr(4'h5, 32'h0);
		rd_chk("status kept", 4'h5, 32'h0000_0080);
		wr(4'h5, 32'h0000_0080);
		@(negedge ref_clk);
		check("irq idle", 0, irq_ff);
		wr(4'h7, 32'h0);
		for (int i = 0; i < 15; i++) begin
			ev(32'h1 << i);
			check("irq masked", 0, irq_ff);
			rd_chk("source", 4'h5, (32'h1 << i) & `INT_SRC_BITS);
			wr(4'h5, 32'h1 << i);
		end
		wr(4'h7, 32'hffff_ffff);
		ev(32'h0000_2000);
		check("irq enabled", 1, irq_ff);
		wr(4'h0, 32'h1);
		@(negedge ref_clk);
		check("soft engines", 1, engines_reset_ff);
		check("soft irq", 0, irq_ff);
		check("soft cfg", 0, cfg_init_ff);
		host_model_inst.settle();
		rd_chk("soft status", 4'h5, 32'h0);
		rd_chk("soft mask", 4'h7, 32'h0);
		arb(1, 2'b00, 4'h0, 4'h1, 4'h0, GRANT_RX);
		arb(1, 2'b00, 4'h1, 4'h0, 4'h0, GRANT_TX);
		arb(1, 2'b00, 4'h2, 4'h2, 4'h0, GRANT_RX);
		arb(1, 2'b00, 4'h4, 4'h4, 4'h8, GRANT_TX);
		arb(1, 2'b00, 4'h8, 4'h8, 4'ha, GRANT_TX);
		arb(1, 2'b00, 4'h1, 4'h8, 4'hc, GRANT_RX);
		arb(1, 2'b00, 4'h2, 4'h4, 4'he, GRANT_TX);
		arb(1, 2'b00, 4'h4, 4'h2, 4'hf, GRANT_RX);
		arb(1, 2'b00, 4'h8, 4'h1, 4'hf, GRANT_TX);
		arb(1, 2'b01, 4'h1, 4'h1, 4'h0, GRANT_TX);
		arb(1, 2'b10, 4'h1, 4'h1, 4'h8, GRANT_RX);
		arb(0, 2'b00, 4'h1, 4'h1, 4'h0, GRANT_TX);
		conclude();
	end
endmodule
